// ===== rtl/ahi_pkg.sv
package ahi_pkg;
    // ------------------------------------------------------------
    // widths and counts
    // ------------------------------------------------------------
    localparam int unsigned DW        = 10;
    localparam int unsigned NCH       = 4;
    localparam int unsigned LATENCY   = 5;
    localparam logic [3:0]  SYNC_BASE = 4'h7;

    // ------------------------------------------------------------
    // device control registers (address on the two address lines)
    // ------------------------------------------------------------
    localparam logic [1:0] CTL0_ADDR    = 2'h0;
    localparam logic [1:0] CTL1_ADDR    = 2'h1;
    localparam int unsigned CTL0_EXTREF = 0;
    localparam int unsigned CTL0_NCH_LO = 1;
    localparam int unsigned CTL1_WOMODE = 0;
    localparam int unsigned CTL1_SYNCRST = 1;
    localparam logic [9:0] CTL0_RESET   = 10'h000;
    localparam logic [9:0] CTL1_RESET   = 10'h000;

    // ------------------------------------------------------------
    // host controller apb map
    // ------------------------------------------------------------
    localparam logic [7:0] APB_CMD  = 8'h00;
    localparam logic [7:0] APB_STAT = 8'h04;
    localparam logic [7:0] APB_RDAT = 8'h08;
    localparam logic [7:0] APB_DIV  = 8'h0c;
    localparam int unsigned CMD_ADDR_LO = 10;
    localparam int unsigned CMD_READ    = 12;
    localparam int unsigned CMD_WOMODE  = 13;
    localparam int unsigned RDAT_FIRST  = 16;
    localparam logic [7:0] DIV_RESET    = 8'h04;

    // ------------------------------------------------------------
    // host access timing, in i_clk cycles (8 ns each)
    // ------------------------------------------------------------
    localparam int unsigned ACC_NS    = 32;
    localparam int unsigned CLK_NS    = 8;
    localparam logic [2:0]  ACC_CYC   = 3'((ACC_NS + CLK_NS - 1) / CLK_NS);

    typedef enum logic [1:0] {
        AHI_IDLE   = 2'h0,
        AHI_SETUP  = 2'h1,
        AHI_STROBE = 2'h3,
        AHI_HOLD   = 2'h2
    } ahi_state_t;
endpackage : ahi_pkg

// ===== rtl/ahi_if.sv
`timescale 1ns/1ns
interface ahi_if;
    logic       select_n;
    logic       select_p;
    logic       rw_wr_n;
    logic       rd_strobe_n;
    logic       reg_addr_bit_low;
    logic       reg_addr_bit_high;
    logic       sample_clock;
    logic       first_chan_n;
    logic [9:0] host_dout;
    logic       host_oe;
    logic [9:0] dev_dout;
    logic       dev_oe;
    logic [9:0] host_data_bus;

    // undriven bus resolves to zero; a clash shows as the host value
    assign host_data_bus = host_oe ? host_dout : (dev_oe ? dev_dout : 10'h000);

    modport dev (
        input  select_n, select_p, rw_wr_n, rd_strobe_n, reg_addr_bit_low,
               reg_addr_bit_high, sample_clock, host_data_bus,
        output first_chan_n, dev_dout, dev_oe
    );
    modport host (
        output select_n, select_p, rw_wr_n, rd_strobe_n, reg_addr_bit_low,
               reg_addr_bit_high, sample_clock, host_dout, host_oe,
        input  first_chan_n, host_data_bus
    );
endinterface : ahi_if

// ===== rtl/ahi_dev.sv
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ns
// Function
// - selected only while select_n low, select_p high
// - sync output marks first-channel word
// - ten-line two-way bus, bit 0 least
// - address lines steer writes to control 0/1
// - combined read/write line or write-only strobe
// - read strobe honoured only in write-only mode
// - host makes its first access a write
// - control 0 selects internal or external reference
// - conversions timed by host-supplied sample clock
// - convert each falling edge, result five later
// - sync low for first channel, idle single-channel
// - first sync seven plus channels after reset
// - read qualifier combines both selects and strobe
module ahi_dev (
    input  wire logic        i_clk,
    input  wire logic        i_arst_n,
    ahi_if.dev               bus,
    input  wire logic [39:0] i_sample,
    output logic             o_ref_external,
    output logic [9:0]       o_ctrl0,
    output logic [9:0]       o_ctrl1,
    output logic             o_conv_tick
);
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic       sel;
    logic       wo_mode;
    logic       rd_act;
    logic       wr_act;
    logic [1:0] addr_in;
    logic [1:0] nch_m1;
    logic       multi;
    logic       fall;

    function automatic logic strobe_active(input logic wo, input logic s,
                                           input logic strobe_n, input logic rw_level);
        strobe_active = s && (wo ? !strobe_n : rw_level);
    endfunction : strobe_active

    always_comb begin
        sel     = !bus.select_n && bus.select_p;
        // power-up strobe mode is undefined; combined mode is taken here
        wo_mode = o_ctrl1[ahi_pkg::CTL1_WOMODE];
        // in combined mode the rw line high means read
        rd_act  = strobe_active(wo_mode, sel, bus.rd_strobe_n, bus.rw_wr_n);
        wr_act  = strobe_active(wo_mode, sel, bus.rw_wr_n, !bus.rw_wr_n);
        addr_in = {bus.reg_addr_bit_high, bus.reg_addr_bit_low};
        nch_m1  = o_ctrl0[ahi_pkg::CTL0_NCH_LO +: 2];
        multi   = (nch_m1 != 2'h0);
    end

    // ------------------------------------------------------------
    // host access capture
    // ------------------------------------------------------------
    logic       wr_q;
    logic       rd_q;
    logic [9:0] wdata_q;
    logic [1:0] waddr_q;
    logic       next_wr_q;
    logic       next_rd_q;
    logic [9:0] next_wdata_q;
    logic [1:0] next_waddr_q;
    logic [9:0] next_ctrl0;
    logic [9:0] next_ctrl1;
    logic       sync_rst;

    always_comb begin
        next_wr_q    = wr_act;
        next_rd_q    = rd_act;
        next_wdata_q = wr_act ? bus.host_data_bus : wdata_q;
        next_waddr_q = wr_act ? addr_in : waddr_q;
        next_ctrl0   = o_ctrl0;
        next_ctrl1   = o_ctrl1;
        sync_rst     = 1'b0;
        // write lands when the write qualifier ends
        // so the last word seen while strobed is the one kept
        if (wr_q && !wr_act) begin
            case (waddr_q)
                ahi_pkg::CTL0_ADDR: begin
                    next_ctrl0 = wdata_q;
                end
                ahi_pkg::CTL1_ADDR: begin
                    // sync reset bit is a command, never stored
                    next_ctrl1 = wdata_q & ~(10'h001 << ahi_pkg::CTL1_SYNCRST);
                    sync_rst   = wdata_q[ahi_pkg::CTL1_SYNCRST];
                end
                default: begin
                    next_ctrl0 = o_ctrl0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_q    <= 1'b0;
            rd_q    <= 1'b0;
            wdata_q <= 10'h000;
            waddr_q <= 2'h0;
            // strobe mode is unknown to the host until its first write
            o_ctrl0 <= ahi_pkg::CTL0_RESET;
            o_ctrl1 <= ahi_pkg::CTL1_RESET;
        end else begin
            wr_q    <= next_wr_q;
            rd_q    <= next_rd_q;
            wdata_q <= next_wdata_q;
            waddr_q <= next_waddr_q;
            o_ctrl0 <= next_ctrl0;
            o_ctrl1 <= next_ctrl1;
        end
    end

    assign o_ref_external = o_ctrl0[ahi_pkg::CTL0_EXTREF];

    // ------------------------------------------------------------
    // conversion pipeline on sample clock falling edges
    // ------------------------------------------------------------
    // channel tag rides with each word so sync follows the word
    logic [9:0] pipe      [ahi_pkg::LATENCY];
    logic [1:0] pipe_tag  [ahi_pkg::LATENCY];
    logic [9:0] next_pipe [ahi_pkg::LATENCY];
    logic [1:0] next_tag  [ahi_pkg::LATENCY];
    logic       clk_q;
    logic [1:0] chan;
    logic [1:0] next_chan;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic [9:0] out_word;
    logic [9:0] next_out_word;
    logic       sync_n;
    logic       next_sync_n;
    logic [3:0] first_at;

    always_comb begin
        fall          = clk_q && !bus.sample_clock;
        first_at      = ahi_pkg::SYNC_BASE + {2'h0, nch_m1} + 4'h1;
        next_chan     = chan;
        next_cnt      = cnt;
        next_out_word = out_word;
        next_sync_n   = sync_n;
        for (int i = 0; i < ahi_pkg::LATENCY; i++) begin
            next_pipe[i] = pipe[i];
            next_tag[i]  = pipe_tag[i];
        end
        if (fall) begin
            next_pipe[0] = i_sample[chan*ahi_pkg::DW +: ahi_pkg::DW];
            next_tag[0]  = chan;
            for (int i = 1; i < ahi_pkg::LATENCY; i++) begin
                next_pipe[i] = pipe[i-1];
                next_tag[i]  = pipe_tag[i-1];
            end
            next_out_word = pipe[ahi_pkg::LATENCY-1];
            next_chan     = (chan >= nch_m1) ? 2'h0 : 2'(chan + 2'h1);
            next_cnt      = (cnt == 4'hf) ? cnt : 4'(cnt + 4'h1);
            // suppressed until first_at falls (seven plus the channel count) have passed since a sync reset
            next_sync_n   = !(multi && (next_cnt >= first_at)
                              && (pipe_tag[ahi_pkg::LATENCY-1] == 2'h0));
        end
        // leaving multichannel releases sync at once, off any fall
        if (!multi) begin
            next_sync_n = 1'b1;
        end
        if (sync_rst) begin
            // last channel first so channel 0 lands at the first sync
            // limitation: a fall on the commit cycle is absorbed here
            next_chan   = nch_m1;
            next_cnt    = 4'h0;
            next_sync_n = 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            clk_q    <= 1'b0;
            chan     <= 2'h0;
            cnt      <= 4'h0;
            out_word <= 10'h000;
            sync_n   <= 1'b1;
            for (int i = 0; i < ahi_pkg::LATENCY; i++) begin
                pipe[i]     <= 10'h000;
                pipe_tag[i] <= 2'h0;
            end
        end else begin
            clk_q    <= bus.sample_clock;
            chan     <= next_chan;
            cnt      <= next_cnt;
            out_word <= next_out_word;
            sync_n   <= next_sync_n;
            for (int i = 0; i < ahi_pkg::LATENCY; i++) begin
                pipe[i]     <= next_pipe[i];
                pipe_tag[i] <= next_tag[i];
            end
        end
    end

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    assign o_conv_tick      = fall;
    assign bus.first_chan_n = sync_n;
    assign bus.dev_dout     = out_word;
    // one cycle behind the read qualifier, released one after it ends
    assign bus.dev_oe       = rd_q;
endmodule : ahi_dev

// ===== rtl/ahi_host.sv
`timescale 1ns/1ns
module ahi_host (
    input  wire logic        i_clk,
    input  wire logic        i_arst_n,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    ahi_if.host              bus
);
    // ------------------------------------------------------------
    // apb slave and registers
    // ------------------------------------------------------------
    ahi_pkg::ahi_state_t st;
    ahi_pkg::ahi_state_t next_st;
    logic [13:0]         cmd;
    logic [13:0]         next_cmd;
    logic [7:0]          div;
    logic [7:0]          next_div;
    logic [9:0]          rdat;
    logic [9:0]          next_rdat;
    logic                rfirst;
    logic                next_rfirst;
    logic [2:0]          tcnt;
    logic [2:0]          next_tcnt;
    logic                apb_wr;
    logic                busy;

    assign busy      = (st != ahi_pkg::AHI_IDLE);
    assign apb_wr    = i_psel && i_penable && i_pwrite;
    assign o_pready  = 1'b1;
    assign o_pslverr = 1'b0;

    always_comb begin
        case (i_paddr)
            ahi_pkg::APB_CMD:  o_prdata = {18'h0, cmd};
            ahi_pkg::APB_STAT: o_prdata = {31'h0, busy};
            ahi_pkg::APB_RDAT: o_prdata = {15'h0, rfirst, 6'h0, rdat};
            ahi_pkg::APB_DIV:  o_prdata = {24'h0, div};
            default:           o_prdata = 32'h0;
        endcase
    end

    // ------------------------------------------------------------
    // access sequencer
    // ------------------------------------------------------------
    logic       rd;
    logic       wo;
    logic       n_sel;
    logic       n_rw;
    logic       n_rd_n;
    logic       n_oe;
    logic       sel_q;
    logic       rw_q;
    logic       rd_n_q;
    logic       oe_q;

    always_comb begin
        next_st     = st;
        next_cmd    = cmd;
        next_div    = div;
        next_rdat   = rdat;
        next_rfirst = rfirst;
        next_tcnt   = tcnt;
        rd          = cmd[ahi_pkg::CMD_READ];
        wo          = cmd[ahi_pkg::CMD_WOMODE];
        if (apb_wr && i_paddr == ahi_pkg::APB_DIV) begin
            next_div = (i_pwdata[7:0] == 8'h0) ? 8'h01 : i_pwdata[7:0];
        end
        case (st)
            ahi_pkg::AHI_IDLE: begin
                // command writes while busy are dropped
                if (apb_wr && i_paddr == ahi_pkg::APB_CMD) begin
                    next_cmd = i_pwdata[13:0];
                    next_st  = ahi_pkg::AHI_SETUP;
                end
            end
            ahi_pkg::AHI_SETUP: begin
                next_tcnt = ahi_pkg::ACC_CYC;
                next_st   = ahi_pkg::AHI_STROBE;
            end
            ahi_pkg::AHI_STROBE: begin
                next_tcnt = 3'(tcnt - 3'h1);
                if (tcnt == 3'h1) begin
                    if (rd) begin
                        next_rdat   = bus.host_data_bus;
                        next_rfirst = !bus.first_chan_n;
                    end
                    next_st = ahi_pkg::AHI_HOLD;
                end
            end
            ahi_pkg::AHI_HOLD: begin
                next_st = ahi_pkg::AHI_IDLE;
            end
            default: begin
                next_st = ahi_pkg::AHI_IDLE;
            end
        endcase
        // decode the command being taken, so pins settle a cycle before select
        rd     = next_cmd[ahi_pkg::CMD_READ];
        wo     = next_cmd[ahi_pkg::CMD_WOMODE];
        // select asserted with both polarities during the strobe only
        n_sel  = (next_st == ahi_pkg::AHI_STROBE);
        // combined mode: rw level; write-only mode: active-low write strobe
        n_rw   = wo ? !(n_sel && !rd) : rd;
        n_rd_n = !(wo && n_sel && rd);
        n_oe   = !rd && (next_st != ahi_pkg::AHI_IDLE);
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st     <= ahi_pkg::AHI_IDLE;
            cmd    <= 14'h0;
            div    <= ahi_pkg::DIV_RESET;
            rdat   <= 10'h0;
            rfirst <= 1'b0;
            tcnt   <= 3'h0;
            sel_q  <= 1'b0;
            rw_q   <= 1'b1;
            rd_n_q <= 1'b1;
            oe_q   <= 1'b0;
        end else begin
            st     <= next_st;
            cmd    <= next_cmd;
            div    <= next_div;
            rdat   <= next_rdat;
            rfirst <= next_rfirst;
            tcnt   <= next_tcnt;
            sel_q  <= n_sel;
            rw_q   <= n_rw;
            rd_n_q <= n_rd_n;
            oe_q   <= n_oe;
        end
    end

    // ------------------------------------------------------------
    // sample clock divider
    // ------------------------------------------------------------
    logic [7:0] dcnt;
    logic [7:0] next_dcnt;
    logic       sclk;
    logic       next_sclk;

    always_comb begin
        next_dcnt = 8'(dcnt + 8'h1);
        next_sclk = sclk;
        if (dcnt + 8'h1 >= div) begin
            next_dcnt = 8'h0;
            next_sclk = !sclk;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            dcnt <= 8'h0;
            sclk <= 1'b0;
        end else begin
            dcnt <= next_dcnt;
            sclk <= next_sclk;
        end
    end

    assign bus.select_n          = !sel_q;
    assign bus.select_p          = sel_q;
    assign bus.rw_wr_n           = rw_q;
    assign bus.rd_strobe_n       = rd_n_q;
    assign bus.reg_addr_bit_low  = cmd[ahi_pkg::CMD_ADDR_LO];
    assign bus.reg_addr_bit_high = cmd[ahi_pkg::CMD_ADDR_LO+1];
    assign bus.host_dout         = cmd[9:0];
    assign bus.host_oe           = oe_q;
    assign bus.sample_clock      = sclk;
endmodule : ahi_host

// ===== verif/ahi_chk_sva.sv
`timescale 1ns/1ns
module ahi_chk (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic select_n,
    input wire logic select_p,
    input wire logic rw_wr_n,
    input wire logic rd_strobe_n,
    input wire logic sample_clock,
    input wire logic first_chan_n,
    input wire logic host_oe,
    input wire logic dev_oe
);
    // ------------------------------------------------------------
    // link protocol properties
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    sequence s_sel_on;
        $fell(select_n);
    endsequence
    sequence s_sel_hold;
        !select_n [*4] ##1 select_n;
    endsequence
    sequence s_sync_on;
        $fell(first_chan_n);
    endsequence

    property p_sel_pulse;
        s_sel_on |-> s_sel_hold;
    endproperty
    property p_oe_sel;
        dev_oe |-> $past(!select_n && select_p);
    endproperty
    property p_oe_end;
        (select_n || !select_p) |=> !dev_oe;
    endproperty
    property p_oe_read;
        dev_oe |-> $past(rw_wr_n) && !host_oe;
    endproperty
    property p_strobe_stable;
        (!select_n && $past(!select_n)) |-> $stable(rw_wr_n) && $stable(rd_strobe_n);
    endproperty
    property p_rd_in_sel;
        !rd_strobe_n |-> !select_n && select_p;
    endproperty
    // sync moves one cycle after a conversion fall, with the clock still low if div is above 1, or off any fall on a sync reset or leaving multichannel
    property p_sync_edge;
        $changed(first_chan_n) |-> !sample_clock;
    endproperty
    property p_sync_width;
        s_sync_on |-> !first_chan_n [*8];
    endproperty

    a_sel_pulse:     assert property (p_sel_pulse)     else $error("select pulse not four cycles");
    a_oe_sel:        assert property (p_oe_sel)        else $error("bus driven while not selected");
    a_oe_end:        assert property (p_oe_end)        else $error("bus still driven after deselect");
    a_oe_read:       assert property (p_oe_read)       else $error("bus driven outside a read");
    a_strobe_stable: assert property (p_strobe_stable) else $error("strobe moved inside access");
    a_rd_in_sel:     assert property (p_rd_in_sel)     else $error("read strobe outside select");
    a_sync_edge:     assert property (p_sync_edge)     else $error("sync moved off a conversion fall");
    a_sync_width:    assert property (p_sync_width)    else $error("sync low too short");
endmodule : ahi_chk

// ===== verif/adc_parallel_host_interface_test.sv
`timescale 1ns/1ns
module adc_parallel_host_interface_test;
    localparam logic [9:0] CH0  = 10'h2a5;
    localparam logic [9:0] CH0B = 10'h1c3;
    logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, ref_ext, tick;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [9:0]  ctrl0, ctrl1;
    logic [39:0] sample;
    int          n_fail, check_count;

    ahi_if link ();
    ahi_dev i_ahi_dev (.i_clk(clk), .i_arst_n(arst_n), .bus(link), .i_sample(sample), .o_ref_external(ref_ext),
                       .o_ctrl0(ctrl0), .o_ctrl1(ctrl1), .o_conv_tick(tick));
    ahi_host i_ahi_host (.i_clk(clk), .i_arst_n(arst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
                         .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
                         .o_pslverr(pslverr), .bus(link));
    ahi_chk i_ahi_chk (.i_clk(clk), .i_arst_n(arst_n), .select_n(link.select_n), .select_p(link.select_p),
                       .rw_wr_n(link.rw_wr_n), .rd_strobe_n(link.rd_strobe_n), .sample_clock(link.sample_clock),
                       .first_chan_n(link.first_chan_n), .host_oe(link.host_oe), .dev_oe(link.dev_oe));

    always #4 clk = ~clk;

    // ------------------------------------------------------------
    // bus and compare helpers
    // ------------------------------------------------------------
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        logic rdy;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            // settled values, as they stand at the coming edge
            @(negedge clk);
            rdy = pready;
            q   = prdata;
            @(posedge clk);
        end while (rdy !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // one device access; polls busy so the next command is never dropped
    task automatic dev_op(input logic [1:0] ra, input logic [9:0] d, input logic rd, input logic wo);
        logic [31:0] q;
        apb(1'b1, ahi_pkg::APB_CMD, {18'h0, wo, rd, ra, d}, q);
        q = 32'h1;
        while (q[0] !== 1'b0) begin
            apb(1'b0, ahi_pkg::APB_STAT, 32'h0, q);
        end
    endtask : dev_op

    task automatic rd_word(input logic wo, output logic [31:0] q);
        dev_op(2'h0, 10'h000, 1'b1, wo);
        apb(1'b0, ahi_pkg::APB_RDAT, 32'h0, q);
    endtask : rd_word

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        logic [31:0] q;
        chk("ctrl0", ahi_pkg::CTL0_RESET, ctrl0);
        chk("ctrl1", ahi_pkg::CTL1_RESET, ctrl1);
        chk("sync idle", 1'b1, link.first_chan_n);
        chk("dev_oe idle", 1'b0, link.dev_oe);
        chk("pslverr", 1'b0, pslverr);
        apb(1'b0, ahi_pkg::APB_DIV, 32'h0, q);
        chk("div reset", ahi_pkg::DIV_RESET, q[7:0]);
        apb(1'b0, 8'h10, 32'h0, q);
        chk("unmapped", 32'h0, q);
        $display("test reset done");
    endtask : t_reset

    task automatic t_config;
        dev_op(2'h1, 10'h000, 1'b0, 1'b0);
        dev_op(2'h0, 10'h001, 1'b0, 1'b0);
        chk("ref external", 1'b1, ref_ext);
        chk("ctrl0", 10'h001, ctrl0);
        dev_op(2'h2, 10'h3ff, 1'b0, 1'b0);
        chk("ctrl0 addr2", 10'h001, ctrl0);
        chk("ctrl1 addr2", 10'h000, ctrl1);
        dev_op(2'h0, 10'h000, 1'b0, 1'b0);
        chk("ref internal", 1'b0, ref_ext);
        $display("test config done");
    endtask : t_config

    task automatic t_read;
        logic [31:0] q;
        repeat (100) @(posedge clk);
        rd_word(1'b0, q);
        chk("read combined", CH0, q[9:0]);
        chk("flag single", 1'b0, q[ahi_pkg::RDAT_FIRST]);
        @(negedge link.sample_clock);
        @(posedge clk);
        sample[9:0] <= CH0B;
        @(negedge link.sample_clock);
        rd_word(1'b0, q);
        chk("read before latency", CH0, q[9:0]);
        repeat (6) @(negedge link.sample_clock);
        rd_word(1'b0, q);
        chk("read after latency", CH0B, q[9:0]);
        dev_op(2'h1, 10'h001, 1'b0, 1'b0);
        chk("ctrl1 strobe mode", 10'h001, ctrl1);
        rd_word(1'b1, q);
        chk("read strobe mode", CH0B, q[9:0]);
        rd_word(1'b0, q);
        chk("combined read ignored", 10'h000, q[9:0]);
        dev_op(2'h1, 10'h000, 1'b0, 1'b1);
        chk("ctrl1 back", 10'h000, ctrl1);
        $display("test read done");
    endtask : t_read

    task automatic t_sync;
        logic [31:0] q;
        int          cnt = 0;
        apb(1'b1, ahi_pkg::APB_DIV, 32'h28, q);
        apb(1'b0, ahi_pkg::APB_DIV, 32'h0, q);
        chk("div", 8'h28, q[7:0]);
        dev_op(2'h0, 10'h006, 1'b0, 1'b0);
        // start in a low half so no fall lands on the reset commit
        @(negedge link.sample_clock);
        dev_op(2'h1, 10'h002, 1'b0, 1'b0);
        for (int k = 0; k < 3000; k++) begin
            @(negedge clk);
            if (link.first_chan_n === 1'b0) break;
            if (tick === 1'b1) cnt++;
        end
        chk("sync delay", 32'(ahi_pkg::SYNC_BASE) + 32'h4, cnt);
        rd_word(1'b0, q);
        chk("first channel word", CH0B, q[9:0]);
        chk("first channel flag", 1'b1, q[ahi_pkg::RDAT_FIRST]);
        $display("test sync done");
    endtask : t_sync

    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : complete_run

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        complete_run();
    end

    initial begin
        clk         = 1'b0;
        arst_n      = 1'b0;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = 8'h00;
        pwdata      = 32'h0;
        sample      = {10'h0f3, 10'h2c1, 10'h155, CH0};
        n_fail      = 0;
        check_count = 0;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_config();
        t_read();
        t_sync();
        complete_run();
    end
endmodule : adc_parallel_host_interface_test
